// ==== shared/rfct_pkg.sv ====
// How it works
// - Any-frame mode plus threshold reached: jam in half duplex, pause in full duplex.
// - Automatic pause only while any-frame bit set and link is full duplex.
// - Half duplex any-frame: skip address decode, act on next valid preamble.
// - That preamble-triggered jam starts one cycle after the preamble is seen.
// - Full duplex any-frame: pause request raised the same cycle threshold is reached.
// - Pause request held pending until the transmitter takes it; no cut-off.
// - Any-frame bit set makes group, all-station and own-address bits ignored.
// - 100 Mb/s jam codes 0..F give 5,10,15,25, then 50..600 us.
// - 10 Mb/s jam codes give the 100 Mb/s time plus 2.2 us.
// - Threshold is 8 bits in 64-byte units, compared with FIFO fill.
// - Jam lasts the selected duration; duration unused in full duplex.
// - Any-frame clear: jam only for enabled group, all-station, own-address frames.
// - Full duplex: one pause per threshold crossing, carrying programmed pause time.
package rfct_pkg;

  localparam int unsigned CLK_PERIOD_NS = 20;

  localparam int unsigned REG_ADDR_W = 8;
  localparam int unsigned FIFO_LVL_W = 16;
  localparam int unsigned FILL_UNIT_SHIFT = 6;
  localparam int unsigned FILL_UNIT_W = FIFO_LVL_W - FILL_UNIT_SHIFT;
  localparam int unsigned JAM_CNT_W = 15;

  localparam logic [7:0] OFS_FLOW_CFG = 8'h00;
  localparam logic [7:0] OFS_PAUSE_TIME = 8'h04;
  localparam logic [7:0] OFS_STATUS = 8'h08;

  localparam int unsigned THR_LSB = 16;
  localparam int unsigned THR_W = 8;
  localparam int unsigned DUR_LSB = 4;
  localparam int unsigned DUR_W = 4;
  localparam int unsigned BIT_EVERY = 0;
  localparam int unsigned BIT_OWN = 1;
  localparam int unsigned BIT_ALL = 2;
  localparam int unsigned BIT_GROUP = 3;

  localparam int unsigned ST_JAM = 0;
  localparam int unsigned ST_PEND = 1;
  localparam int unsigned ST_REACHED = 2;
  localparam int unsigned ST_FDX = 3;
  localparam int unsigned ST_SPEED = 4;
  localparam int unsigned ST_LEVEL_LSB = 16;

  localparam logic [31:0] FLOW_CFG_RST = 32'h0000_0000;
  localparam logic [31:0] FLOW_CFG_MASK = 32'h00FF_00FF;
  localparam logic [15:0] PAUSE_TIME_RST = 16'h0000;

  typedef int unsigned rfct_ns_tbl_t [16];

  // Jam times at 100 Mb/s, in ns
  localparam rfct_ns_tbl_t JAM_NS_100M = '{
    5000, 10000, 15000, 25000, 50000, 100000, 150000, 200000,
    250000, 300000, 350000, 400000, 450000, 500000, 550000, 600000};
  localparam int unsigned JAM_EXTRA_10M_NS = 2200;

  typedef enum logic [1:0] {
    PS_ARMED = 2'b00,
    PS_PENDING = 2'b01,
    PS_SENT = 2'b10
  } rfct_pause_st_t;

  // Least times: round up, never below one cycle
  function automatic rfct_ns_tbl_t rfct_cyc_tbl(rfct_ns_tbl_t ns, int unsigned extra);
    rfct_ns_tbl_t cyc;
    for (int i = 0; i < 16; i++) begin
      cyc[i] = (ns[i] + extra + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
      if (cyc[i] == 0) begin
        cyc[i] = 1;
      end
    end
    return cyc;
  endfunction

endpackage

// ==== shared/rfct_jam_if.sv ====
interface rfct_jam_if;
  logic load;
  logic [3:0] sel;
  logic speed100;
  logic busy;
  modport ctrl (output load, output sel, output speed100, input busy);
  modport timer (input load, input sel, input speed100, output busy);
endinterface

// ==== logic/rfct_jam_timer.sv ====
module rfct_jam_timer import rfct_pkg::*; #(
  parameter rfct_ns_tbl_t JAM_NS = JAM_NS_100M,
  parameter int unsigned EXTRA_NS = JAM_EXTRA_10M_NS
) (
  input logic clock,
  input logic rst_b,
  rfct_jam_if.timer jam
);

  localparam rfct_ns_tbl_t CYC_FAST = rfct_cyc_tbl(JAM_NS, 0);
  localparam rfct_ns_tbl_t CYC_SLOW = rfct_cyc_tbl(JAM_NS, EXTRA_NS);
  // End points worked out apart from the table function, so the checks follow the parameters
  localparam int unsigned FAST_MIN_CYC = (JAM_NS[0] + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned SLOW_MAX_CYC = (JAM_NS[15] + EXTRA_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  logic [JAM_CNT_W-1:0] count;
  logic [JAM_CNT_W-1:0] next_count;
  logic [JAM_CNT_W-1:0] loadVal;

  always_comb begin
    loadVal = jam.speed100 ? JAM_CNT_W'(CYC_FAST[jam.sel]) : JAM_CNT_W'(CYC_SLOW[jam.sel]);
    if (jam.load) begin
      // Retrigger restarts the full period
      next_count = loadVal;
    end else if (count != '0) begin
      next_count = count - 1'b1;
    end else begin
      next_count = count;
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      count <= '0;
    end else begin
      count <= next_count;
    end
  end

  assign jam.busy = (count != '0);

  ////////////////////////////////////////////////////////////////////////
  a_jam_reload: assert property (@(posedge clock) disable iff (!rst_b)
    jam.load |=> (count == $past(loadVal)) && jam.busy)
    else $error("jam counter not reloaded");
  a_jam_fast_min: assert property (@(posedge clock) disable iff (!rst_b)
    (jam.load && jam.speed100 && jam.sel == 4'h0) |=> count == JAM_CNT_W'(FAST_MIN_CYC))
    else $error("shortest fast jam has wrong length");
  a_jam_slow_max: assert property (@(posedge clock) disable iff (!rst_b)
    (jam.load && !jam.speed100 && jam.sel == 4'hF) |=> count == JAM_CNT_W'(SLOW_MAX_CYC))
    else $error("longest slow jam has wrong length");

endmodule

// ==== logic/rfct_trigger.sv ====
module rfct_trigger import rfct_pkg::*; #(
  parameter rfct_ns_tbl_t JAM_NS = JAM_NS_100M,
  parameter int unsigned EXTRA_NS = JAM_EXTRA_10M_NS
) (
  input logic clock,
  input logic rst_b,
  input logic [REG_ADDR_W-1:0] regAddr,
  input logic [31:0] regWrData,
  input logic regWrite,
  input logic regRead,
  output logic [31:0] regRdData,
  input logic [FIFO_LVL_W-1:0] rxFifoLevel,
  input logic fullDuplex,
  input logic speed100,
  input logic rxPreambleValid,
  input logic rxFrameDecoded,
  input logic rxIsGroup,
  input logic rxIsAllStation,
  input logic rxIsOwnAddr,
  output logic txPauseReq,
  input logic txPauseAck,
  output logic [15:0] pauseTimeValue,
  output logic backPressure
);

  ////////////////////////////////////////////////////////////////////////
  // Register file

  logic [31:0] flowCfg;
  logic [31:0] next_flowCfg;
  logic [15:0] pauseTime;
  logic [15:0] next_pauseTime;
  logic [31:0] next_rdData;
  logic [31:0] status;

  logic [THR_W-1:0] fill_trigger_threshold;
  logic [DUR_W-1:0] jam_duration_sel;
  logic flow_ctl_every_frame;
  logic flow_ctl_group_frame;
  logic flow_ctl_all_station_frame;
  logic flow_ctl_own_addr_frame;

  logic [FILL_UNIT_W-1:0] fillUnits;
  logic reached;
  logic fdEnabled;
  logic pauseFire;
  logic hdMatch;
  logic jamFire;
  logic jamBusy;

  rfct_pause_st_t pauseState;
  rfct_pause_st_t next_pauseState;

  rfct_jam_if jamBus ();

  assign fill_trigger_threshold = flowCfg[THR_LSB +: THR_W];
  assign jam_duration_sel = flowCfg[DUR_LSB +: DUR_W];
  assign flow_ctl_every_frame = flowCfg[BIT_EVERY];
  assign flow_ctl_group_frame = flowCfg[BIT_GROUP];
  assign flow_ctl_all_station_frame = flowCfg[BIT_ALL];
  assign flow_ctl_own_addr_frame = flowCfg[BIT_OWN];

  always_comb begin
    status = '0;
    status[ST_JAM] = backPressure;
    status[ST_PEND] = (pauseState == PS_PENDING);
    status[ST_REACHED] = reached;
    status[ST_FDX] = fullDuplex;
    status[ST_SPEED] = speed100;
    status[ST_LEVEL_LSB +: FILL_UNIT_W] = fillUnits;
  end

  always_comb begin
    next_flowCfg = flowCfg;
    next_pauseTime = pauseTime;
    next_rdData = '0;
    // Unmapped writes are dropped, unmapped reads return zero
    if (regWrite) begin
      case (regAddr)
        OFS_FLOW_CFG: begin
          next_flowCfg = regWrData & FLOW_CFG_MASK;
        end
        OFS_PAUSE_TIME: begin
          next_pauseTime = regWrData[15:0];
        end
        default: begin
          next_flowCfg = flowCfg;
        end
      endcase
    end
    if (regRead) begin
      case (regAddr)
        OFS_FLOW_CFG: begin
          next_rdData = flowCfg;
        end
        OFS_PAUSE_TIME: begin
          next_rdData = {16'h0000, pauseTime};
        end
        OFS_STATUS: begin
          next_rdData = status;
        end
        default: begin
          next_rdData = '0;
        end
      endcase
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      flowCfg <= FLOW_CFG_RST;
      pauseTime <= PAUSE_TIME_RST;
      regRdData <= '0;
    end else begin
      flowCfg <= next_flowCfg;
      pauseTime <= next_pauseTime;
      regRdData <= next_rdData;
    end
  end

  // Pause time travels with the request
  assign pauseTimeValue = pauseTime;

  ////////////////////////////////////////////////////////////////////////
  // Threshold compare

  assign fillUnits = rxFifoLevel[FIFO_LVL_W-1:FILL_UNIT_SHIFT];
  assign reached = fillUnits >= FILL_UNIT_W'(fill_trigger_threshold);

  ////////////////////////////////////////////////////////////////////////
  // Full-duplex pause request

  assign fdEnabled = flow_ctl_every_frame && fullDuplex;
  // Combinational so the request shows in the crossing cycle
  assign pauseFire = (pauseState == PS_ARMED) && fdEnabled && reached;
  assign txPauseReq = (pauseState == PS_PENDING) || pauseFire;

  always_comb begin
    next_pauseState = pauseState;
    case (pauseState)
      PS_ARMED: begin
        if (pauseFire) begin
          next_pauseState = txPauseAck ? PS_SENT : PS_PENDING;
        end
      end
      PS_PENDING: begin
        // Kept even if the level drops; the transmitter sends it when free
        if (txPauseAck) begin
          next_pauseState = PS_SENT;
        end
      end
      PS_SENT: begin
        // One frame per crossing, re-armed once below threshold
        if (!reached || !fdEnabled) begin
          next_pauseState = PS_ARMED;
        end
      end
      default: begin
        next_pauseState = PS_ARMED;
      end
    endcase
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      pauseState <= PS_ARMED;
    end else begin
      pauseState <= next_pauseState;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Half-duplex jam

  always_comb begin
    if (flow_ctl_every_frame) begin
      // No address decode; preamble start is enough
      hdMatch = rxPreambleValid;
    end else begin
      hdMatch = rxFrameDecoded && ((flow_ctl_group_frame && rxIsGroup) ||
        (flow_ctl_all_station_frame && rxIsAllStation) ||
        (flow_ctl_own_addr_frame && rxIsOwnAddr));
    end
  end

  assign jamFire = !fullDuplex && reached && hdMatch;

  assign jamBus.load = jamFire;
  assign jamBus.sel = jam_duration_sel;
  assign jamBus.speed100 = speed100;
  assign jamBusy = jamBus.busy;
  // Duration has no meaning in full duplex, so jam is gated off there
  assign backPressure = jamBusy && !fullDuplex;

  rfct_jam_timer #(
    .JAM_NS(JAM_NS),
    .EXTRA_NS(EXTRA_NS)
  ) u_jam_timer (
    .clock(clock),
    .rst_b(rst_b),
    .jam(jamBus)
  );

  ////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_b);

  a_pause_needs_fdx: assert property (
    $rose(txPauseReq) |-> fullDuplex && flowCfg[BIT_EVERY] && reached)
    else $error("pause request outside full-duplex any-frame mode");

  a_pause_same_cycle: assert property (
    (pauseState == PS_ARMED && fullDuplex && flowCfg[BIT_EVERY] && reached) |-> txPauseReq)
    else $error("pause request late at threshold");

  a_pause_held: assert property (
    (txPauseReq && !txPauseAck) |=> txPauseReq)
    else $error("pending pause request dropped");

  a_pause_single: assert property (
    txPauseAck && txPauseReq ##1 reached |-> !txPauseReq)
    else $error("second pause frame in one crossing");

  a_jam_any_preamble: assert property (
    (rxPreambleValid && flowCfg[BIT_EVERY] && !fullDuplex && reached) |=> backPressure || fullDuplex)
    else $error("no jam on preamble in any-frame mode");

  a_jam_ignores_sel: assert property (
    (flowCfg[BIT_EVERY] && !rxPreambleValid && !jamBusy) |=> !backPressure)
    else $error("selection bits acted in any-frame mode");

  a_jam_select: assert property (
    (!flowCfg[BIT_EVERY] && flowCfg[BIT_GROUP] && rxFrameDecoded && rxIsGroup && reached && !fullDuplex)
    |=> backPressure || fullDuplex)
    else $error("no jam on enabled group frame");

  a_jam_not_fdx: assert property (
    fullDuplex |-> !backPressure)
    else $error("jam asserted in full duplex");

  a_quiet_no_sel: assert property (
    (flowCfg[3:0] == 4'h0 && !jamBusy && pauseState != PS_PENDING) |-> !txPauseReq ##1 !backPressure)
    else $error("flow control active with no selection bit");

  a_jam_thr_gate: assert property (
    $rose(jamBusy) |-> $past(reached))
    else $error("jam started below threshold");

  ////////////////////////////////////////////////////////////////////////
  // Pause side

  a_pause_ack_done: assert property (
    (txPauseReq && txPauseAck) |=> !txPauseReq)
    else $error("pause request stayed up after the ack");

  a_pause_hdx_quiet: assert property (
    (!(fullDuplex && flowCfg[BIT_EVERY]) && pauseState != PS_PENDING) |-> !txPauseReq)
    else $error("pause request without full-duplex any-frame mode");

  a_pend_kept: assert property (
    (pauseState == PS_PENDING && !txPauseAck) |=> pauseState == PS_PENDING)
    else $error("pending pause lost before the ack");

  // Re-arming below threshold, or when full-duplex any-frame mode is off, keeps it to one frame per crossing
  a_sent_rearm: assert property (
    (pauseState == PS_SENT && !reached) |=> pauseState == PS_ARMED)
    else $error("pause not re-armed below threshold");

  a_pause_time_hold: assert property (
    (txPauseReq && !txPauseAck && !regWrite) |=> $stable(pauseTimeValue))
    else $error("pause time moved under a pending request");

  ////////////////////////////////////////////////////////////////////////
  // Jam side

  // Level counts bytes, threshold counts 64-byte units
  a_fill_compare: assert property (
    reached == (rxFifoLevel >= {flowCfg[THR_LSB +: THR_W], FILL_UNIT_SHIFT'(0)}))
    else $error("threshold compare wrong");

  a_jam_below_thr: assert property (
    (!reached && !jamBusy) |=> !backPressure)
    else $error("jam started below threshold level");

  a_jam_sel_off: assert property (
    (!flowCfg[BIT_EVERY] && !rxFrameDecoded && !jamBusy) |=> !backPressure)
    else $error("jam without a decoded frame in selective mode");

  a_jam_hdx_idle: assert property (
    (!jamBusy && !jamFire) |=> !backPressure)
    else $error("jam with no trigger");

  // A retrigger must not open a gap in the jam
  a_jam_retrigger: assert property (
    (jamFire && jamBusy) |=> backPressure || fullDuplex)
    else $error("retriggered jam dropped");

  a_jam_status: assert property (
    (regRead && regAddr == OFS_STATUS) |=> regRdData[ST_JAM] == $past(backPressure))
    else $error("status jam bit disagrees with output");

  c_jam_retrigger: cover property (jamFire && jamBusy);
  c_pause_handshake: cover property (pauseFire ##[1:20] txPauseAck);
  c_jam_preamble: cover property (flowCfg[BIT_EVERY] && jamFire ##1 backPressure);
  c_jam_group: cover property (!flowCfg[BIT_EVERY] && jamFire && rxIsGroup);
  c_pause_rearm: cover property (pauseState == PS_SENT ##1 pauseState == PS_ARMED);

endmodule

// ==== sim/rfct_mac_tx_model.sv ====
module rfct_mac_tx_model (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic txPauseReq,
  input wire logic [15:0] pauseTimeValue,
  input wire logic [2:0] ackDelay,
  output logic txPauseAck,
  output int ackCount,
  output logic [15:0] lastPauseTime
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2:0] waitCnt;

  // A frame already on the wire delays the ack; the request must stand until then
  always @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      waitCnt <= 3'h0;
      txPauseAck <= 1'h0;
      ackCount <= 0;
      lastPauseTime <= 16'h0000;
    end else begin
      txPauseAck <= 1'h0;
      if (txPauseReq && txPauseAck) begin
        ackCount <= ackCount + 1;
        lastPauseTime <= pauseTimeValue;
        waitCnt <= 3'h0;
      end else if (txPauseReq) begin
        if (waitCnt == ackDelay) begin
          txPauseAck <= 1'h1;
        end else begin
          waitCnt <= waitCnt + 3'h1;
        end
      end
    end
  end
endmodule

// ==== sim/rfct_trigger_tb_top.sv ====
`define CHK(act, exp) begin check_count++; if ((act) !== (exp)) begin num_errors++; \
  $display("Error at %0t: got %h expected %h", $time, (act), (exp)); end end

module rfct_trigger_tb_top import rfct_pkg::*; ();
  timeunit 1ns;
  timeprecision 1ps;
  // Short jam table keeps every code and both speeds inside one run
  localparam rfct_ns_tbl_t TB_NS = '{40, 60, 80, 100, 120, 140, 160, 180, 200, 220, 240, 260, 280, 300, 320, 340};
  localparam int unsigned TB_EXTRA = 40;
  logic clock = 1'h0;
  logic rst_b;
  logic [7:0] regAddr;
  logic [31:0] regWrData, regRdData, r, got32;
  logic regWrite, regRead, fullDuplex, speed100, rxPreambleValid, rxFrameDecoded;
  logic rxIsGroup, rxIsAllStation, rxIsOwnAddr, txPauseReq, txPauseAck, backPressure;
  logic [15:0] rxFifoLevel, pauseTimeValue, lastPauseTime, pt, above, below;
  logic [7:0] thr;
  logic [2:0] ackDelay;
  logic rdPend = 1'h0;
  int ackCount, expJam;
  int num_errors = 0;
  int check_count = 0;
  int jamLen = 0;
  int seed = 32'h0000_5f39;
  logic [31:0] rdQ[$];
  int jamQ[$];

  always #10 clock = ~clock;

  rfct_trigger #(.JAM_NS(TB_NS), .EXTRA_NS(TB_EXTRA)) i_dut (.clock(clock), .rst_b(rst_b), .regAddr(regAddr),
    .regWrData(regWrData), .regWrite(regWrite), .regRead(regRead), .regRdData(regRdData),
    .rxFifoLevel(rxFifoLevel), .fullDuplex(fullDuplex), .speed100(speed100), .rxPreambleValid(rxPreambleValid),
    .rxFrameDecoded(rxFrameDecoded), .rxIsGroup(rxIsGroup), .rxIsAllStation(rxIsAllStation),
    .rxIsOwnAddr(rxIsOwnAddr), .txPauseReq(txPauseReq), .txPauseAck(txPauseAck),
    .pauseTimeValue(pauseTimeValue), .backPressure(backPressure));

  rfct_mac_tx_model i_mac (.clock(clock), .rst_b(rst_b), .txPauseReq(txPauseReq), .pauseTimeValue(pauseTimeValue),
    .ackDelay(ackDelay), .txPauseAck(txPauseAck), .ackCount(ackCount), .lastPauseTime(lastPauseTime));

  function automatic int jamCycles(input logic [3:0] c, input logic s);
    return (TB_NS[c] + (s ? 0 : TB_EXTRA)) / CLK_PERIOD_NS;
  endfunction

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    regAddr <= a;
    regWrData <= d;
    regWrite <= 1'h1;
    @(posedge clock);
    regWrite <= 1'h0;
    @(posedge clock);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    regAddr <= a;
    regRead <= 1'h1;
    rdQ.push_back(e);
    @(posedge clock);
    regRead <= 1'h0;
    @(posedge clock);
  endtask

  task automatic preamble();
    rxPreambleValid <= 1'h1;
    @(posedge clock);
    rxPreambleValid <= 1'h0;
  endtask

  task automatic decoded(input logic [2:0] f);
    {rxIsGroup, rxIsAllStation, rxIsOwnAddr} <= f;
    rxFrameDecoded <= 1'h1;
    @(posedge clock);
    rxFrameDecoded <= 1'h0;
    repeat (20) @(posedge clock);
  endtask

  task automatic setup(input logic [3:0] code, input logic [3:0] sel, input logic spd);
    speed100 <= spd;
    wr(OFS_FLOW_CFG, {8'h00, thr, 8'h00, code, sel});
  endtask

  task automatic complete_run();
    $display("Comparisons %0d, mismatches %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // An unexpected jam finds the queue empty and is compared against zero
  always @(posedge clock) begin
    if (rdPend) begin
      got32 = rdQ.pop_front();
      `CHK(regRdData, got32)
    end
    rdPend <= regRead;
    if (backPressure === 1'h1) begin
      jamLen++;
    end else if (jamLen != 0) begin
      expJam = (jamQ.size() != 0) ? jamQ.pop_front() : 0;
      `CHK(jamLen, expJam)
      jamLen = 0;
    end
  end

  initial begin
    repeat (20000) @(posedge clock);
    num_errors++;
    complete_run();
  end

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    {regAddr, regWrData, regWrite, regRead, rxFifoLevel, fullDuplex, speed100} = '0;
    {rxPreambleValid, rxFrameDecoded, rxIsGroup, rxIsAllStation, rxIsOwnAddr, ackDelay, rst_b} = '0;
    repeat (20) @(posedge clock);
    rst_b <= 1'h1;
    @(posedge clock);
    rd(OFS_FLOW_CFG, FLOW_CFG_RST);
    rd(OFS_PAUSE_TIME, 32'h0000_0000);
    rd(8'h0C, 32'h0000_0000);
    r = $random(seed);
    wr(OFS_FLOW_CFG, r);
    rd(OFS_FLOW_CFG, r & FLOW_CFG_MASK);
    pt = 16'($random(seed));
    wr(OFS_PAUSE_TIME, {16'h0000, pt});
    rd(OFS_PAUSE_TIME, {16'h0000, pt});
    `CHK(pauseTimeValue, pt)
    thr = 8'($random(seed)) | 8'h01;
    above = {2'h0, thr, 6'($random(seed))};
    below = {2'h0, thr, 6'h00} - 16'h0001;
    rxFifoLevel <= above;
    // Every code at both speeds, odd codes retriggered mid-jam
    for (int s = 0; s < 2; s++) begin
      for (int c = 0; c < 16; c++) begin
        setup(4'(c), 4'hF, 1'(s));
        jamQ.push_back(jamCycles(4'(c), 1'(s)) + (c % 2) * 3);
        preamble();
        if (c % 2 == 1) begin
          repeat (2) @(posedge clock);
          preamble();
        end
        repeat (jamCycles(4'(c), 1'(s)) + 4) @(posedge clock);
      end
    end
    rxFifoLevel <= below;
    preamble();
    repeat (20) @(posedge clock);
    rxFifoLevel <= above;
    for (int k = 1; k < 4; k++) begin
      setup(4'h2, 4'(1 << k), 1'h1);
      preamble();
      decoded(~3'(1 << (k - 1)));
      jamQ.push_back(jamCycles(4'h2, 1'h1));
      decoded(3'(1 << (k - 1)));
    end
    setup(4'h0, 4'hF, 1'h1);
    decoded(3'h7);
    setup(4'h0, 4'h0, 1'h1);
    preamble();
    decoded(3'h7);
    `CHK(ackCount, 0)
    fullDuplex <= 1'h1;
    for (int i = 0; i < 2; i++) begin
      rxFifoLevel <= below;
      setup(4'h0, 4'(i * 14), 1'h1);
      rxFifoLevel <= above;
      repeat (20) @(posedge clock);
      `CHK(ackCount, 0)
    end
    // Status seen with the level below threshold on a full-duplex 100 Mb/s link
    r = (32'(below[15:6]) << ST_LEVEL_LSB) | (32'h0000_0001 << ST_FDX) | (32'h0000_0001 << ST_SPEED);
    // Pause: prompt ack with level held, then slow ack after level drops
    for (int i = 0; i < 2; i++) begin
      ackDelay <= 3'(i * 6);
      rxFifoLevel <= below;
      setup(4'h0, 4'h1, 1'h1);
      rxFifoLevel <= above;
      #1;
      `CHK(txPauseReq, 1'h1)
      @(posedge clock);
      if (i == 1) begin
        rxFifoLevel <= below;
        rd(OFS_STATUS, r | (32'h0000_0001 << ST_PEND));
      end
      repeat (3) @(posedge clock);
      #1;
      `CHK(txPauseReq, 1'(i))
      preamble();
      repeat (20) @(posedge clock);
      `CHK(ackCount, i + 1)
      `CHK(lastPauseTime, pt)
    end
    rd(OFS_STATUS, r);
    complete_run();
  end
endmodule
